// ---- rtl/snp_defs.svh ----
`ifndef SNP_DEFS_SVH
`define SNP_DEFS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define SNP_BYTE_W 8
`define SNP_LANES 4
`define SNP_SYNC_W 8
`define SNP_CNT_W 4

// ----------------------------------------
// synchroniser bit positions
// ----------------------------------------
`define SNP_SY_CS 0
`define SNP_SY_CLK 1
`define SNP_SY_IO 4
`define SNP_LANE_WP 2
`define SNP_LANE_HOLD 3

// ----------------------------------------
// reset values
// ----------------------------------------
// select resets low, so a select held low through reset is never a fall
`define SNP_SYNC_RST 8'hFC
`define SNP_OE_OFF 4'hF
`define SNP_LANE_OFF 4'h0
`define SNP_CNT_ZERO 4'h0

// ----------------------------------------
// output enable patterns (low drives)
// ----------------------------------------
`define SNP_OE_SINGLE 4'hD
`define SNP_OE_DUAL 4'hC
`define SNP_OE_QUAD 4'h0

`endif

// ---- rtl/snp_pkg.sv ----
package snp_pkg;

  typedef enum logic [2:0] {
    SNP_SINGLE = 3'h1,
    SNP_DUAL = 3'h2,
    SNP_QUAD = 3'h4
  } snp_lane_e;

  typedef enum logic [2:0] {
    SNP_IDLE = 3'h1,
    SNP_RUN = 3'h2,
    SNP_PAUSE = 3'h4
  } snp_state_e;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe_n;
  } snp_pad_s;

endpackage : snp_pkg

// ---- rtl/snp_sync.sv ----
`timescale 1ns/1ps
`include "snp_defs.svh"

module snp_sync #(
  parameter int W = `SNP_SYNC_W,
  parameter logic [W-1:0] RST_VAL = `SNP_SYNC_RST
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // ----------------------------------------
  // two stage synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_reg <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule : snp_sync

// ---- rtl/snp_shift.sv ----
`timescale 1ns/1ps
`include "snp_defs.svh"

module snp_shift #(
  parameter int W = `SNP_BYTE_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic clr_i,
  input wire logic cap_i,
  input wire logic launch_i,
  input wire snp_pkg::snp_lane_e lanes_i,
  // serial side
  input wire logic [3:0] din_i,
  output logic [3:0] dout_o,
  // parallel side
  input wire logic [W-1:0] tx_byte_i,
  output logic tx_take_o,
  output logic [W-1:0] rx_byte_o,
  output logic rx_done_o
);

  logic [W-1:0] rx_reg;
  logic [W-1:0] rx_next;
  logic [W-1:0] tx_reg;
  logic [W-1:0] tx_src;
  logic [`SNP_CNT_W-1:0] rx_cnt_reg;
  logic [`SNP_CNT_W-1:0] tx_cnt_reg;
  logic [`SNP_CNT_W-1:0] step;

  // bits moved per clock edge for a lane mode
  function automatic logic [`SNP_CNT_W-1:0] snp_step(input snp_pkg::snp_lane_e l);
    unique case (l)
      snp_pkg::SNP_DUAL: snp_step = 4'h2;
      snp_pkg::SNP_QUAD: snp_step = 4'h4;
      default: snp_step = 4'h1;
    endcase
  endfunction : snp_step

  // shift a word left by the lane width, filling from the lanes
  function automatic logic [W-1:0] snp_shl(input logic [W-1:0] v, input logic [3:0] d,
                                           input snp_pkg::snp_lane_e l);
    unique case (l)
      snp_pkg::SNP_DUAL: snp_shl = {v[W-3:0], d[1:0]};
      snp_pkg::SNP_QUAD: snp_shl = {v[W-5:0], d[3:0]};
      default: snp_shl = {v[W-2:0], d[0]};
    endcase
  endfunction : snp_shl

  assign step = snp_step(lanes_i);
  assign rx_next = snp_shl(rx_reg, din_i, lanes_i);
  assign tx_src = (tx_cnt_reg == `SNP_CNT_ZERO) ? tx_byte_i : tx_reg;
  assign tx_take_o = launch_i && (tx_cnt_reg == `SNP_CNT_ZERO);

  // ----------------------------------------
  // capture on rising clock edges
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_reg <= '0;
      rx_cnt_reg <= `SNP_CNT_ZERO;
      rx_byte_o <= '0;
      rx_done_o <= 1'b0;
    end
    else
    begin
      rx_done_o <= 1'b0;
      if (clr_i)
        rx_cnt_reg <= `SNP_CNT_ZERO;
      else if (cap_i)
      begin
        rx_reg <= rx_next;
        if (rx_cnt_reg + step == `SNP_CNT_W'(W))
        begin
          rx_cnt_reg <= `SNP_CNT_ZERO;
          rx_byte_o <= rx_next;
          rx_done_o <= 1'b1;
        end
        else
          rx_cnt_reg <= rx_cnt_reg + step;
      end
    end
  end

  // ----------------------------------------
  // launch on falling clock edges
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_reg <= '0;
      tx_cnt_reg <= `SNP_CNT_ZERO;
      dout_o <= `SNP_LANE_OFF;
    end
    else if (clr_i)
      tx_cnt_reg <= `SNP_CNT_ZERO;
    else if (launch_i)
    begin
      tx_reg <= snp_shl(tx_src, `SNP_LANE_OFF, lanes_i);
      unique case (lanes_i)
        snp_pkg::SNP_DUAL: dout_o <= {2'h0, tx_src[W-1:W-2]};
        snp_pkg::SNP_QUAD: dout_o <= tx_src[W-1:W-4];
        default: dout_o <= {2'h0, tx_src[W-1], 1'b0};
      endcase
      if (tx_cnt_reg + step == `SNP_CNT_W'(W))
        tx_cnt_reg <= `SNP_CNT_ZERO;
      else
        tx_cnt_reg <= tx_cnt_reg + step;
    end
  end

endmodule : snp_shift

// ---- rtl/snp_pin_if.sv ----
`timescale 1ns/1ps
`include "snp_defs.svh"


module snp_pin_if #(
  parameter int W = `SNP_BYTE_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_i,
  output snp_pkg::snp_pad_s pad_o,
  // command core: lane use and data
  input wire snp_pkg::snp_lane_e lane_mode_i,
  input wire logic out_phase_i,
  input wire logic [W-1:0] tx_byte_i,
  output logic tx_take_o,
  output logic [W-1:0] rx_byte_o,
  output logic rx_valid_o,
  // command core: frame status
  output logic frame_start_o,
  output logic frame_end_o,
  output logic selected_o,
  output logic paused_o,
  // protection
  input wire logic wp_enable_i,
  input wire logic [3:0] block_protect_bits_i,
  input wire logic [1:0] status_protect_bits_i,
  output logic write_block_o,
  output logic protection_reg_lock_o,
  output logic region_lock_o,
  output logic quad_reject_o,
  // internal program or erase cycle
  input wire logic cycle_start_i,
  input wire logic cycle_done_i,
  output logic cycle_busy_o
);

  logic [`SNP_SYNC_W-1:0] sync_q;
  logic cs_s;
  logic cs_d_reg;
  logic sclk_s;
  logic sclk_d_reg;
  logic [3:0] io_s;
  logic hold_n_s;
  logic wp_n_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic armed_reg;
  logic seen_rise_reg;
  logic quad_lock_reg;
  logic quad_busy;
  logic wp_guard_reg;
  logic cycle_busy_reg;
  logic drive;
  logic cap;
  logic launch;
  logic [3:0] dout;
  logic [3:0] oe_n_next;
  snp_pkg::snp_lane_e eff_lanes;
  snp_pkg::snp_state_e state_reg;
  snp_pkg::snp_state_e state_next;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  snp_sync #(
    .W(`SNP_SYNC_W),
    .RST_VAL(`SNP_SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({io_i, 2'h3, sclk_i, cs_n_i}),
    .q_o(sync_q)
  );

  assign cs_s = sync_q[`SNP_SY_CS];
  assign sclk_s = sync_q[`SNP_SY_CLK];
  assign io_s = sync_q[`SNP_SY_IO +: `SNP_LANES];
  assign wp_n_s = io_s[`SNP_LANE_WP];
  assign hold_n_s = io_s[`SNP_LANE_HOLD];

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_d_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
    end
    else
    begin
      cs_d_reg <= cs_s;
      sclk_d_reg <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_d_reg;
  assign sclk_fall = !sclk_s && sclk_d_reg;
  assign cs_fall = !cs_s && cs_d_reg;

  // ----------------------------------------
  // power-up arming
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      armed_reg <= 1'b0;
    else if (cs_fall)
      armed_reg <= 1'b1;
  end

  // ----------------------------------------
  // lane mode and quad handling
  // ----------------------------------------
  // quad with hardware protect falls back to single and drives nothing
  assign quad_reject_o = wp_enable_i && (lane_mode_i == snp_pkg::SNP_QUAD);
  assign eff_lanes = quad_reject_o ? snp_pkg::SNP_SINGLE : lane_mode_i;
  assign quad_busy = quad_lock_reg || (eff_lanes == snp_pkg::SNP_QUAD);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      quad_lock_reg <= 1'b0;
    else if (state_reg == snp_pkg::SNP_IDLE)
      quad_lock_reg <= 1'b0;
    else if (state_reg == snp_pkg::SNP_RUN && eff_lanes == snp_pkg::SNP_QUAD)
      quad_lock_reg <= 1'b1;
  end

  // ----------------------------------------
  // select and pause state machine
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      snp_pkg::SNP_IDLE:
        if (!cs_s && (armed_reg || cs_fall))
          state_next = snp_pkg::SNP_RUN;
      snp_pkg::SNP_RUN:
        if (cs_s)
          state_next = snp_pkg::SNP_IDLE;
        else if (!hold_n_s && !quad_busy && !sclk_s)
          state_next = snp_pkg::SNP_PAUSE;
      snp_pkg::SNP_PAUSE:
        if (cs_s)
          state_next = snp_pkg::SNP_IDLE;
        else if (hold_n_s && !sclk_s)
          state_next = snp_pkg::SNP_RUN;
      default:
        state_next = snp_pkg::SNP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_reg <= snp_pkg::SNP_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      frame_start_o <= 1'b0;
      frame_end_o <= 1'b0;
    end
    else
    begin
      frame_start_o <= (state_reg == snp_pkg::SNP_IDLE) && (state_next == snp_pkg::SNP_RUN);
      frame_end_o <= (state_reg != snp_pkg::SNP_IDLE) && (state_next == snp_pkg::SNP_IDLE);
    end
  end

  assign selected_o = state_reg != snp_pkg::SNP_IDLE;
  assign paused_o = state_reg == snp_pkg::SNP_PAUSE;

  // ----------------------------------------
  // serial data path
  // ----------------------------------------
  // a leading fall with an idle-high clock precedes any data bit
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      seen_rise_reg <= 1'b0;
    else if (state_reg == snp_pkg::SNP_IDLE)
      seen_rise_reg <= 1'b0;
    else if (sclk_rise && state_reg == snp_pkg::SNP_RUN)
      seen_rise_reg <= 1'b1;
  end

  // paused state freezes shifters so the operation resumes where it stopped
  assign cap = (state_reg == snp_pkg::SNP_RUN) && sclk_rise && !out_phase_i;
  assign launch = (state_reg == snp_pkg::SNP_RUN) && sclk_fall && seen_rise_reg && out_phase_i;

  snp_shift #(
    .W(W)
  ) u_shift (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(state_reg == snp_pkg::SNP_IDLE),
    .cap_i(cap),
    .launch_i(launch),
    .lanes_i(eff_lanes),
    .din_i(io_s),
    .dout_o(dout),
    .tx_byte_i(tx_byte_i),
    .tx_take_o(tx_take_o),
    .rx_byte_o(rx_byte_o),
    .rx_done_o(rx_valid_o)
  );

  // ----------------------------------------
  // pad drive
  // ----------------------------------------
  // the host must already have released shared lanes in the output phase
  assign drive = (state_reg == snp_pkg::SNP_RUN) && !cs_s && out_phase_i && !quad_reject_o;

  always_comb
  begin
    oe_n_next = `SNP_OE_OFF;
    if (drive)
    begin
      unique case (eff_lanes)
        snp_pkg::SNP_DUAL: oe_n_next = `SNP_OE_DUAL;
        snp_pkg::SNP_QUAD: oe_n_next = `SNP_OE_QUAD;
        default: oe_n_next = `SNP_OE_SINGLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pad_o.oe_n <= `SNP_OE_OFF;
      pad_o.o <= `SNP_LANE_OFF;
    end
    else
    begin
      pad_o.oe_n <= oe_n_next;
      pad_o.o <= dout;
    end
  end

  // ----------------------------------------
  // write protection
  // ----------------------------------------
  // the pin is only a guard while it is not a quad data lane
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      wp_guard_reg <= 1'b0;
    else if (!quad_busy)
      wp_guard_reg <= !wp_n_s;
  end

  assign write_block_o = wp_enable_i && wp_guard_reg;
  assign protection_reg_lock_o = wp_guard_reg && (wp_enable_i || status_protect_bits_i[0]);
  assign region_lock_o = protection_reg_lock_o && (block_protect_bits_i != 4'h0);

  // ----------------------------------------
  // internal cycle tracking
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cycle_busy_reg <= 1'b0;
    else if (cycle_start_i && !write_block_o)
      cycle_busy_reg <= 1'b1;
    else if (cycle_done_i)
      cycle_busy_reg <= 1'b0;
  end

  assign cycle_busy_o = cycle_busy_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  deselect_hiz_a: assert property (cs_s [*3] |-> pad_o.oe_n == `SNP_OE_OFF)
    else $error("lanes driven while deselected");
  cycle_keep_a: assert property (cycle_busy_reg && cs_s && !cycle_done_i |=> cycle_busy_reg)
    else $error("internal cycle dropped on deselect");
  select_run_a: assert property (armed_reg && state_reg == snp_pkg::SNP_IDLE && !cs_s
    |=> state_reg == snp_pkg::SNP_RUN)
    else $error("select not taken");
  unarmed_idle_a: assert property (!armed_reg |-> state_reg == snp_pkg::SNP_IDLE)
    else $error("active before first select fall");
  quad_reject_a: assert property (wp_enable_i && lane_mode_i == snp_pkg::SNP_QUAD
    |=> pad_o.oe_n == `SNP_OE_OFF)
    else $error("quad drive with hardware protect");
  pause_hiz_a: assert property (state_reg == snp_pkg::SNP_PAUSE |=> pad_o.oe_n == `SNP_OE_OFF)
    else $error("lanes driven while paused");
  pause_edge_a: assert property (state_reg == snp_pkg::SNP_RUN && sclk_s
    |=> state_reg != snp_pkg::SNP_PAUSE)
    else $error("pause began with clock high");
  quad_nopause_a: assert property (quad_lock_reg && state_reg == snp_pkg::SNP_RUN
    |=> state_reg != snp_pkg::SNP_PAUSE)
    else $error("pause during quad operation");
  hw_block_a: assert property (wp_enable_i && !quad_busy && !wp_n_s |=> write_block_o || !wp_enable_i)
    else $error("write not blocked by protect pin");

endmodule : snp_pin_if

// ---- tb/snp_host_model.sv ----
`timescale 1ns/1ps

module snp_host_model (
  // clock
  input wire logic clk_i,
  // serial pins
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o,
  output logic [3:0] io_en_o,
  input wire logic [3:0] io_i
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'hF;
    io_en_o = 4'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // idle level of the clock picks mode 0 or 3
  task automatic open_frame(input logic idle);
    @(posedge clk_i);
    sclk_o <= idle;
    tick(2);
    cs_n_o <= 1'b0;
    tick(6);
  endtask : open_frame

  task automatic close_frame();
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    io_en_o <= 4'h0;
    tick(8);
  endtask : close_frame

  task automatic sclk_low();
    @(posedge clk_i);
    sclk_o <= 1'b0;
    tick(4);
  endtask : sclk_low

  // host lets go of the shared lanes before the device answers
  task automatic release_lanes();
    @(posedge clk_i);
    io_en_o <= 4'h0;
  endtask : release_lanes

  task automatic pin(input int k, input logic v);
    @(posedge clk_i);
    io_o[k] <= v;
    io_en_o[k] <= 1'b1;
  endtask : pin

  // one beat per 8 clocks: fall, drive, rise, sample late in the high half
  task automatic xfer(input int lanes, input int nbits, input logic rd, input logic [7:0] tx,
                      output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    repeat (nbits / lanes)
    begin
      @(posedge clk_i);
      sclk_o <= 1'b0;
      io_en_o[1:0] <= rd ? 2'h0 : (lanes == 1 ? 2'h1 : 2'h3);
      if (lanes == 4)
        io_en_o[3:2] <= rd ? 2'h0 : 2'h3;
      case (lanes)
        1: io_o[0] <= sh[7];
        2: io_o[1:0] <= sh[7:6];
        default: io_o <= sh[7:4];
      endcase
      sh = sh << lanes;
      tick(4);
      sclk_o <= 1'b1;
      tick(3);
      case (lanes)
        1: rx = {rx[6:0], io_i[1]};
        2: rx = {rx[5:0], io_i[1:0]};
        default: rx = {rx[3:0], io_i};
      endcase
    end
  endtask : xfer
endmodule : snp_host_model

// ---- tb/serial_nand_pin_interface_tb_top.sv ----
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
  begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", nm, (exp), (got)); end end

module serial_nand_pin_interface_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n, sclk, tgl, out_phase, tx_take, rx_valid, fr_start, fr_end, selected, paused;
  logic wp_en, write_block, preg_lock, region_lock, quad_reject, cyc_start, cyc_done, busy;
  logic [3:0] io_h, io_en, io_w, bp;
  logic [1:0] sp;
  logic [7:0] rx_byte, last_rx, tx_byte;
  snp_pkg::snp_pad_s pad;
  snp_pkg::snp_lane_e lane_mode;
  int n_fail = 0;
  int compares = 0;
  int n_rx = 0;
  int n_take = 0;
  int n_fs = 0;
  int n_fe = 0;

  always #12.5 clk_i = ~clk_i;

  // ----------------------------------------
  // wire levels: device, host, then pull-ups or a changing pattern
  // ----------------------------------------
  initial tgl = 1'b0;
  always @(posedge clk_i) tgl <= ~tgl;
  always_comb
    for (int k = 0; k < 4; k++)
      io_w[k] = (pad.oe_n[k] === 1'b0) ? pad.o[k] : io_en[k] ? io_h[k] : (k > 1 ? 1'b1 : tgl);

  always @(posedge clk_i)
    if (rx_valid === 1'b1)
    begin
      last_rx <= rx_byte;
      n_rx <= n_rx + 1;
    end

  always @(posedge clk_i)
  begin
    if (tx_take === 1'b1)
      n_take <= n_take + 1;
    if (fr_start === 1'b1)
      n_fs <= n_fs + 1;
    if (fr_end === 1'b1)
      n_fe <= n_fe + 1;
  end

  snp_host_model u_host (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(io_h), .io_en_o(io_en),
    .io_i(io_w));

  snp_pin_if #(.W(8)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_w),
    .pad_o(pad), .lane_mode_i(lane_mode), .out_phase_i(out_phase), .tx_byte_i(tx_byte),
    .tx_take_o(tx_take), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .frame_start_o(fr_start),
    .frame_end_o(fr_end), .selected_o(selected), .paused_o(paused), .wp_enable_i(wp_en),
    .block_protect_bits_i(bp), .status_protect_bits_i(sp), .write_block_o(write_block),
    .protection_reg_lock_o(preg_lock), .region_lock_o(region_lock), .quad_reject_o(quad_reject),
    .cycle_start_i(cyc_start), .cycle_done_i(cyc_done), .cycle_busy_o(busy));

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power();
    logic [7:0] rx;
    int n0;
    u_host.open_frame(1'b0);
    rst_i <= 1'b1;
    u_host.tick(2);
    rst_i <= 1'b0;
    u_host.tick(2);
    n0 = n_rx;
    u_host.xfer(1, 8, 1'b0, 8'h81, rx);
    u_host.tick(4);
    `CHK("ignored", n0, n_rx)
    `CHK("selected", 1'b0, selected)
    u_host.close_frame();
    $display("test power done");
  endtask : t_power

  task automatic t_lanes();
    logic [7:0] rx;
    int t0;
    int s0;
    int e0;
    t0 = n_take;
    s0 = n_fs;
    e0 = n_fe;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_i);
      lane_mode <= i == 0 ? snp_pkg::SNP_SINGLE : i == 1 ? snp_pkg::SNP_DUAL : snp_pkg::SNP_QUAD;
      tx_byte <= 8'hC3 + 8'(i * 17);
      u_host.open_frame(i == 2);
      u_host.xfer(1 << i, 8, 1'b0, 8'hA5 ^ 8'(i), rx);
      u_host.tick(4);
      `CHK("rx_byte", 8'hA5 ^ 8'(i), last_rx)
      `CHK("selected", 1'b1, selected)
      u_host.release_lanes();
      u_host.tick(1);
      out_phase <= 1'b1;
      u_host.xfer(1 << i, 8, 1'b1, 8'h00, rx);
      `CHK("read", 8'hC3 + 8'(i * 17), rx)
      `CHK("oe_n", i == 0 ? 4'hD : i == 1 ? 4'hC : 4'h0, pad.oe_n)
      u_host.close_frame();
      `CHK("released", 4'hF, pad.oe_n)
      out_phase <= 1'b0;
    end
    `CHK("takes", t0 + 3, n_take)
    `CHK("starts", s0 + 3, n_fs)
    `CHK("ends", e0 + 3, n_fe)
    $display("test lanes done");
  endtask : t_lanes

  task automatic t_pause();
    logic [7:0] rx;
    lane_mode <= snp_pkg::SNP_SINGLE;
    u_host.open_frame(1'b0);
    u_host.xfer(1, 4, 1'b0, 8'h50, rx);
    u_host.sclk_low();
    u_host.pin(3, 1'b0);
    for (int k = 0; k < 12 && paused !== 1'b1; k++) @(posedge clk_i);
    `CHK("paused", 1'b1, paused)
    u_host.xfer(1, 8, 1'b0, 8'hFF, rx);
    `CHK("oe_n", 4'hF, pad.oe_n)
    u_host.pin(3, 1'b1);
    u_host.tick(4);
    `CHK("held", 1'b1, paused)
    u_host.xfer(1, 4, 1'b0, 8'hC0, rx);
    u_host.tick(4);
    `CHK("resumed", 8'h5C, last_rx)
    u_host.close_frame();
    lane_mode <= snp_pkg::SNP_QUAD;
    u_host.open_frame(1'b0);
    u_host.xfer(4, 8, 1'b0, 8'h3C, rx);
    u_host.sclk_low();
    u_host.pin(3, 1'b0);
    u_host.tick(10);
    `CHK("no pause", 1'b0, paused)
    u_host.close_frame();
    $display("test pause done");
  endtask : t_pause

  task automatic t_protect();
    logic [7:0] rx;
    @(posedge clk_i);
    cyc_start <= 1'b1;
    @(posedge clk_i);
    cyc_start <= 1'b0;
    u_host.open_frame(1'b0);
    u_host.close_frame();
    `CHK("busy", 1'b1, busy)
    cyc_done <= 1'b1;
    @(posedge clk_i);
    cyc_done <= 1'b0;
    u_host.tick(3);
    `CHK("idle", 1'b0, busy)
    lane_mode <= snp_pkg::SNP_SINGLE;
    wp_en <= 1'b1;
    bp <= 4'hC;
    u_host.open_frame(1'b0);
    u_host.pin(2, 1'b0);
    u_host.xfer(1, 8, 1'b0, 8'h06, rx);
    u_host.tick(4);
    `CHK("blocked", 1'b1, write_block)
    `CHK("region", 1'b1, region_lock)
    cyc_start <= 1'b1;
    @(posedge clk_i);
    cyc_start <= 1'b0;
    u_host.tick(3);
    `CHK("no cycle", 1'b0, busy)
    u_host.close_frame();
    wp_en <= 1'b0;
    sp <= 2'h3;
    bp <= 4'h0;
    u_host.open_frame(1'b0);
    u_host.pin(2, 1'b0);
    u_host.xfer(1, 8, 1'b0, 8'h06, rx);
    u_host.tick(4);
    `CHK("soft", 1'b0, write_block)
    `CHK("reg lock", 1'b1, preg_lock)
    `CHK("no region", 1'b0, region_lock)
    u_host.close_frame();
    wp_en <= 1'b1;
    lane_mode <= snp_pkg::SNP_QUAD;
    u_host.open_frame(1'b0);
    `CHK("reject", 1'b1, quad_reject)
    out_phase <= 1'b1;
    u_host.xfer(4, 8, 1'b1, 8'h00, rx);
    `CHK("no drive", 4'hF, pad.oe_n)
    u_host.close_frame();
    out_phase <= 1'b0;
    wp_en <= 1'b0;
    $display("test protect done");
  endtask : t_protect

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  initial
  begin
    lane_mode = snp_pkg::SNP_SINGLE;
    out_phase = 1'b0;
    wp_en = 1'b0;
    bp = 4'h0;
    sp = 2'h0;
    cyc_start = 1'b0;
    cyc_done = 1'b0;
    tx_byte = 8'hC3;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    u_host.tick(3);
    `CHK("reset oe_n", 4'hF, pad.oe_n)
    t_power();
    t_lanes();
    t_pause();
    t_protect();
    test_done();
  end

  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    test_done();
  end
endmodule : serial_nand_pin_interface_tb_top
